//--- ebc_bus_ctrl.sv
// External bus cycle controller: regular, fast and CPU-space cycles
// Functional notes
// [RULE1] Drive address and size to start transfer
// [RULE2] Far side decodes size and low address
// [RULE3] Peripheral moves data, then acknowledges port width
// [RULE4] Read data valid soon after acknowledge
// [RULE5] Three clocks minimum, wait until acknowledge
// [RULE6] Always-on monitor faults after selected limit
// [RULE7] Far side aborts unanswered or invalid access
// [RULE8] Fault plus halt acts as fault alone
// [RULE9] Reads: two bytes for word, one byte
// [RULE10] Writes: two bytes for word, one byte
// [RULE11] Fast termination completes in two clocks
// [RULE12] Fast cycles acknowledged internally
// [RULE13] Acknowledge option code 1110 means fast
// [RULE14] Fast device read data by S4
// [RULE15] Fast mode: data strobe on reads only
// [RULE16] Overlapping fast selects programmed consistently
// [RULE17] Space code valid with address strobe
// [RULE18] CPU-space type on address bits 19:16
// [RULE19] Software and hardware breakpoints both acknowledged
// [RULE20] Capture read data edge after acknowledge
// [RULE21] Cycle ends on acknowledge or autovector
// [RULE22] Hold address, size, direction, space until end
module ebc_bus_ctrl import ebc_pkg::*; (
	input wire logic i_ref_clk, // 20 MHz system clock
	input wire logic i_rst, // Synchronous reset, active high
	input wire logic i_req, // Core transfer request pulse
	input wire logic i_req_rd, // 1 read, 0 write
	input wire logic [1:0] i_req_size, // Operand length code
	input wire logic [23:0] i_req_addr, // Operand address
	input wire logic [2:0] i_req_space, // Address space for request
	input wire logic [15:0] i_req_wdata, // Write operand, byte in low bits
	input wire logic [3:0] i_cs_ack_opt, // Acknowledge option of matching chip select
	input wire logic [1:0] i_monitor_timeout_sel, // Bus monitor limit select
	input wire logic i_sw_break, // Software breakpoint pulse
	input wire logic [2:0] i_sw_break_num, // Software breakpoint number
	input wire logic i_low_power_stop, // Stop broadcast request pulse
	input wire logic [2:0] i_stop_mask, // Interrupt mask for broadcast
	input wire logic [1:0] i_data_size_ack_n, // Acknowledge pins, active low
	input wire logic i_bus_fault_n, // Bus fault pin, active low
	input wire logic i_halt_n, // Halt pin, active low
	input wire logic i_autovector_request_n, // Autovector pin, active low
	input wire logic i_breakpoint_input_n, // Hardware breakpoint pin, active low
	input wire logic [15:0] i_data, // Data bus pin input
	output logic [23:0] o_addr, // Address bus
	output logic [1:0] o_transfer_size, // Size lines
	output logic [2:0] o_space_code, // Address space code
	output logic o_rd_wr, // 1 read, 0 write
	output logic o_address_strobe_n, // Address strobe, active low
	output logic o_data_strobe_n, // Data strobe, active low
	output logic [15:0] o_data, // Data bus pin output
	output logic o_data_oe, // Data bus output enable
	output logic o_busy, // Cycle in progress
	output logic o_done, // Cycle finished pulse
	output logic o_fault, // Cycle ended by bus fault pulse
	output logic o_timeout, // Fault came from bus monitor
	output logic o_port_16, // Last read answered by 16-bit port
	output logic [15:0] o_rdata // Read data, right aligned
);
	ebc_mon_if mon_link ();

	ebc_bus_monitor #(.MAX_CYC(MON_MAX_CYC)) u_mon (
		.i_ref_clk(i_ref_clk),
		.i_rst(i_rst),
		.mon(mon_link)
	);

	// Pin synchronisers; logic reads stage two, plus a third breakpoint stage for edge detect
	logic [1:0] ack_m_reg;
	logic [1:0] ack_s_reg;
	logic fault_m_reg;
	logic fault_s_reg;
	logic halt_m_reg;
	logic halt_s_reg;
	logic vec_m_reg;
	logic vec_s_reg;
	logic brk_m_reg;
	logic brk_s_reg;
	logic brk_d_reg;
	logic [15:0] data_m_reg;
	logic [15:0] data_s_reg;

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			ack_m_reg <= ACK_NONE;
			ack_s_reg <= ACK_NONE;
			fault_m_reg <= 1'b1;
			fault_s_reg <= 1'b1;
			halt_m_reg <= 1'b1;
			halt_s_reg <= 1'b1;
			vec_m_reg <= 1'b1;
			vec_s_reg <= 1'b1;
			brk_m_reg <= 1'b1;
			brk_s_reg <= 1'b1;
			brk_d_reg <= 1'b1;
			data_m_reg <= DATA_RST;
			data_s_reg <= DATA_RST;
		end else begin
			ack_m_reg <= i_data_size_ack_n;
			ack_s_reg <= ack_m_reg;
			fault_m_reg <= i_bus_fault_n;
			fault_s_reg <= fault_m_reg;
			halt_m_reg <= i_halt_n;
			halt_s_reg <= halt_m_reg;
			vec_m_reg <= i_autovector_request_n;
			vec_s_reg <= vec_m_reg;
			brk_m_reg <= i_breakpoint_input_n;
			brk_s_reg <= brk_m_reg;
			brk_d_reg <= brk_s_reg;
			data_m_reg <= i_data;
			data_s_reg <= data_m_reg;
		end
	end

	ebc_state_t st_reg;
	ebc_state_t st_next;
	logic brk_pend_reg;
	logic fast_rd_d1_reg;
	logic fast_rd_d2_reg;
	logic [23:0] addr_reg;
	logic [1:0] size_reg;
	logic [2:0] space_reg;
	logic rd_reg;
	logic fast_reg;
	logic addr_strobe_n_reg;
	logic data_strobe_n_reg;
	logic [15:0] wdata_reg;
	logic oe_reg;
	logic busy_reg;
	logic done_reg;
	logic fault_reg;
	logic timeout_reg;
	logic term_fault_reg;
	logic term_tmo_reg;
	logic port16_reg;
	logic port16_seen_reg;
	logic [15:0] rdata_reg;

	// Halt is ignored here: with a fault it behaves as the fault alone
	wire halt_seen = !halt_s_reg;
	wire fault_in = !fault_s_reg; // [RULE8]
	wire ack_in = ebc_acked(ack_s_reg, vec_s_reg); // [RULE21]
	wire port16_in = (ack_s_reg != ACK_8BIT) || !vec_s_reg;
	wire brk_fall = brk_d_reg && !brk_s_reg;

	// A fast read waits two more clocks for its data to clear the pin synchroniser
	wire fast_rd_end = (st_reg == ST_FAST) && rd_reg; // [RULE14]
	wire in_idle = (st_reg == ST_IDLE) && !fast_rd_d1_reg && !fast_rd_d2_reg;
	wire take_hw = in_idle && brk_pend_reg;
	wire take_sw = in_idle && !brk_pend_reg && i_sw_break;
	wire take_lp = in_idle && !brk_pend_reg && !i_sw_break && i_low_power_stop;
	wire take_rq = in_idle && !brk_pend_reg && !i_sw_break && !i_low_power_stop && i_req;
	wire start = take_hw || take_sw || take_lp || take_rq;
	wire cpu_cyc = take_hw || take_sw || take_lp;

	wire [23:0] sw_addr = {4'h0, CPU_BRKACK, 11'h000, i_sw_break_num, 2'h0}; // [RULE18] [RULE19]
	wire [23:0] st_addr = take_hw ? HW_BRK_ADDR : // [RULE19]
		take_sw ? sw_addr :
		take_lp ? STOPCAST_ADDR : i_req_addr; // [RULE18]
	wire st_rd = take_lp ? 1'b0 : (take_hw || take_sw) ? 1'b1 : i_req_rd;
	wire [1:0] st_size = cpu_cyc ? SIZE_WORD : i_req_size; // [RULE1]
	wire [2:0] st_space = cpu_cyc ? SPACE_CPU : i_req_space; // [RULE17]
	// Stop broadcast uses internal acknowledge with fast write timing
	wire st_fast = take_lp || (take_rq && i_cs_ack_opt == ACK_OPT_FAST); // [RULE13]
	wire st_byte = (st_size == SIZE_BYTE);
	// A byte goes out on both lanes so either port width finds it
	wire [15:0] st_wdata = take_lp ? {13'h0000, i_stop_mask} :
		st_byte ? {i_req_wdata[7:0], i_req_wdata[7:0]} : i_req_wdata; // [RULE10]

	// Read lane steering by size, low address bit and answering port width
	wire rd_byte = (size_reg == SIZE_BYTE);
	wire [15:0] rd_lane = (port16_reg && rd_byte && addr_reg[0]) ? {8'h00, data_s_reg[7:0]} :
		(!port16_reg || rd_byte) ? {8'h00, data_s_reg[15:8]} : data_s_reg; // [RULE9]
	wire [15:0] fast_lane = (rd_byte && addr_reg[0]) ? {8'h00, data_s_reg[7:0]} :
		rd_byte ? {8'h00, data_s_reg[15:8]} : data_s_reg; // [RULE9] [RULE14]

	wire wait_end = ack_in || fault_in || mon_link.expired; // [RULE5] [RULE6]

	always_comb begin
		st_next = st_reg;
		case (st_reg)
			ST_IDLE: begin
				if (start) begin
					st_next = ST_ADDR;
				end
			end
			ST_ADDR: begin
				st_next = fast_reg ? ST_FAST : ST_WAIT; // [RULE11]
			end
			ST_WAIT: begin
				if (wait_end) begin
					st_next = ST_LATCH; // [RULE5]
				end
			end
			ST_LATCH: begin
				st_next = ST_IDLE;
			end
			ST_FAST: begin
				st_next = ST_IDLE; // [RULE11] [RULE12]
			end
			default: begin
				st_next = ST_IDLE;
			end
		endcase
	end

	assign mon_link.active = (st_reg == ST_WAIT); // [RULE6]
	assign mon_link.sel = i_monitor_timeout_sel;

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			st_reg <= ST_IDLE;
			brk_pend_reg <= 1'b0;
			fast_rd_d1_reg <= 1'b0;
			fast_rd_d2_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			// A new edge outranks the clear taken by a starting cycle
			brk_pend_reg <= brk_fall || (brk_pend_reg && !take_hw); // [RULE19]
			fast_rd_d1_reg <= fast_rd_end; // [RULE14]
			fast_rd_d2_reg <= fast_rd_d1_reg;
		end
	end

	// Cycle attributes load only when idle, so they stay put to the end
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			addr_reg <= ADDR_RST;
			size_reg <= SIZE_LONG;
			space_reg <= 3'h0;
			rd_reg <= 1'b1;
			fast_reg <= 1'b0;
			wdata_reg <= DATA_RST;
		end else if (start) begin
			addr_reg <= st_addr; // [RULE1] [RULE22]
			size_reg <= st_size; // [RULE22]
			space_reg <= st_space; // [RULE22]
			rd_reg <= st_rd;
			fast_reg <= st_fast;
			wdata_reg <= st_wdata; // [RULE10]
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			addr_strobe_n_reg <= 1'b1;
			data_strobe_n_reg <= 1'b1;
			oe_reg <= 1'b0;
			busy_reg <= 1'b0;
		end else begin
			busy_reg <= (st_next != ST_IDLE) || fast_rd_end || fast_rd_d1_reg;
			if (st_reg == ST_ADDR) begin
				addr_strobe_n_reg <= 1'b0; // [RULE17]
				data_strobe_n_reg <= fast_reg && !rd_reg; // [RULE15]
			end else if (st_reg == ST_LATCH || st_reg == ST_FAST) begin
				addr_strobe_n_reg <= 1'b1;
				data_strobe_n_reg <= 1'b1;
			end
			if (start) begin
				oe_reg <= !st_rd; // [RULE10]
			end else if (st_reg == ST_LATCH || st_reg == ST_FAST) begin
				oe_reg <= 1'b0;
			end
		end
	end

	// Termination is noted when seen; read data is taken one clock later
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			term_fault_reg <= 1'b0;
			term_tmo_reg <= 1'b0;
			port16_reg <= 1'b0;
		end else if (st_reg == ST_WAIT && wait_end) begin
			term_fault_reg <= fault_in || mon_link.expired; // [RULE6] [RULE8]
			term_tmo_reg <= mon_link.expired && !fault_in;
			port16_reg <= port16_in;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			done_reg <= 1'b0;
			fault_reg <= 1'b0;
			timeout_reg <= 1'b0;
			rdata_reg <= DATA_RST;
			port16_seen_reg <= 1'b0;
		end else begin
			done_reg <= (st_reg == ST_LATCH) || (st_reg == ST_FAST && !rd_reg) || fast_rd_d2_reg;
			fault_reg <= (st_reg == ST_LATCH) && term_fault_reg;
			timeout_reg <= (st_reg == ST_LATCH) && term_tmo_reg;
			if (st_reg == ST_LATCH && rd_reg && !term_fault_reg) begin
				rdata_reg <= rd_lane; // [RULE20]
				port16_seen_reg <= port16_reg;
			end else if (fast_rd_d2_reg) begin
				rdata_reg <= fast_lane; // [RULE12] [RULE14]
				port16_seen_reg <= 1'b1;
			end
		end
	end

	assign o_addr = addr_reg;
	assign o_transfer_size = size_reg;
	assign o_space_code = space_reg;
	assign o_rd_wr = rd_reg;
	assign o_address_strobe_n = addr_strobe_n_reg;
	assign o_data_strobe_n = data_strobe_n_reg;
	assign o_data = wdata_reg;
	assign o_data_oe = oe_reg;
	assign o_busy = busy_reg;
	assign o_done = done_reg;
	assign o_fault = fault_reg;
	assign o_timeout = timeout_reg;
	assign o_port_16 = port16_seen_reg;
	assign o_rdata = rdata_reg;
endmodule

//--- ebc_bus_ctrl_asserts.sv
// Concurrent checks on the bus cycle controller ports
module ebc_bus_ctrl_asserts import ebc_pkg::*; (
	input wire logic i_ref_clk, // Clock
	input wire logic i_rst, // Reset
	input wire logic i_req, // Request
	input wire logic i_sw_break, // Soft break
	input wire logic i_low_power_stop, // Stop
	input wire logic [3:0] i_cs_ack_opt, // Ack option
	input wire logic [1:0] i_monitor_timeout_sel, // Limit
	input wire logic [1:0] i_data_size_ack_n, // Ack
	input wire logic i_autovector_request_n, // Vector
	input wire logic [23:0] o_addr, // Address
	input wire logic [1:0] o_transfer_size, // Size
	input wire logic [2:0] o_space_code, // Space
	input wire logic o_rd_wr, // Direction
	input wire logic o_address_strobe_n, // Address strobe
	input wire logic o_data_strobe_n, // Data strobe
	input wire logic o_busy, // Busy
	input wire logic o_done, // Done
	input wire logic o_fault, // Fault
	input wire logic o_timeout // Timeout
);
	timeunit 1ns;
	timeprecision 1ns;
	logic fast_q, ack_seen;
	logic [7:0] wcnt, lim;
	assign lim = 8'h40 >> i_monitor_timeout_sel;
	default clocking @(posedge i_ref_clk);
	endclocking
	default disable iff (i_rst);
	// Fast mode is only visible at the take edge, so it is remembered
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			fast_q <= 1'b0;
			ack_seen <= 1'b0;
			wcnt <= 8'h00;
		end else begin
			if (!o_busy && (i_req || i_sw_break || i_low_power_stop)) begin
				fast_q <= i_low_power_stop || (!i_sw_break && i_cs_ack_opt == ACK_OPT_FAST);
			end
			ack_seen <= o_busy && (ack_seen || i_data_size_ack_n != ACK_NONE || !i_autovector_request_n);
			wcnt <= o_address_strobe_n ? 8'h00 : wcnt + 8'h01;
		end
	end
	sequence fast_go_s;
		$fell(o_address_strobe_n) && fast_q;
	endsequence
	sequence reg_go_s;
		$fell(o_address_strobe_n) && !fast_q;
	endsequence
	hold_addr_a: assert property (
		!o_address_strobe_n && !$past(o_address_strobe_n) |-> $stable(o_addr)
		&& $stable(o_transfer_size) && $stable(o_space_code) && $stable(o_rd_wr))
		else $error("address group moved");
	cpu_type_a: assert property (
		!o_address_strobe_n && o_space_code == SPACE_CPU |-> o_addr[19:16] inside {4'h0, 4'h3, 4'hf})
		else $error("bad cpu cycle type");
	fast_end_a: assert property (
		fast_go_s |=> o_address_strobe_n && !o_fault && (o_done || o_rd_wr))
		else $error("fast cycle not two clocks");
	fast_data_a: assert property (fast_go_s and o_rd_wr |-> ##3 (o_done && !o_busy))
		else $error("fast read data late");
	fast_wr_a: assert property (o_busy && fast_q && !o_rd_wr |-> o_data_strobe_n)
		else $error("data strobe on fast write");
	fast_rd_a: assert property (fast_go_s and o_rd_wr |-> !o_data_strobe_n)
		else $error("no data strobe on fast read");
	reg_min_a: assert property (reg_go_s |-> (!o_address_strobe_n && !o_done) [*2])
		else $error("regular cycle too short");
	ack_need_a: assert property (o_done && !o_fault && !fast_q |-> ack_seen)
		else $error("ended without acknowledge");
	mon_lim_a: assert property (
		o_timeout |-> o_fault && o_done && wcnt + 8'h01 >= lim && wcnt <= lim + 8'h04)
		else $error("monitor limit wrong");
endmodule

//--- ebc_bus_ctrl_tb.sv
// Self-checking bench for the external bus cycle controller
module ebc_bus_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import ebc_pkg::*;
	logic i_ref_clk, i_rst, i_req, i_req_rd, i_sw_break, i_low_power_stop, i_breakpoint_input_n;
	logic i_bus_fault_n, i_halt_n, i_autovector_request_n, o_rd_wr, o_address_strobe_n, m_p16;
	logic o_data_strobe_n, o_data_oe, o_busy, o_done, o_fault, o_timeout, o_port_16;
	logic [1:0] i_req_size, i_monitor_timeout_sel, i_data_size_ack_n, o_transfer_size;
	logic [2:0] i_req_space, i_sw_break_num, i_stop_mask, o_space_code, cap_space, m_mode;
	logic [3:0] i_cs_ack_opt;
	logic [7:0] m_wait;
	logic [15:0] i_req_wdata, i_data, o_data, o_rdata, m_data, cap_data;
	logic [23:0] i_req_addr, o_addr, cap_addr;
	int errors = 0;
	int samples_checked = 0;
	assign i_data = o_data_oe ? o_data : m_data;
	ebc_bus_ctrl uut (.*);
	ebc_periph_model far (.i_clk(i_ref_clk), .i_as_n(o_address_strobe_n), .i_rd_wr(o_rd_wr),
		.i_addr(o_addr), .i_space(o_space_code), .i_bus(i_data), .i_wait(m_wait), .i_p16(m_p16),
		.i_mode(m_mode), .o_ack_n(i_data_size_ack_n), .o_fault_n(i_bus_fault_n),
		.o_halt_n(i_halt_n), .o_data(m_data), .o_cap_addr(cap_addr), .o_cap_space(cap_space),
		.o_cap_data(cap_data));
	task automatic chk(input logic [23:0] g, input logic [23:0] e);
		samples_checked++;
		if (g !== e) begin
			errors++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic tally_and_finish;
		$display("errors %0d samples_checked %0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// Kind 0 request, 1 soft breakpoint, 2 stop broadcast, 3 breakpoint pin
	task automatic run(input int k, input logic r, input logic [1:0] s, input logic [23:0] a,
		input logic [15:0] w, input logic [3:0] o, input logic [7:0] t, input logic p,
		input logic [2:0] m);
		int n;
		@(posedge i_ref_clk);
		{i_req_rd, i_req_size, i_req_addr, i_req_wdata, i_cs_ack_opt} <= {r, s, a, w, o};
		{m_wait, m_p16, m_mode, i_req_space} <= {t, p, m, 1'b0, r, 1'b1};
		{i_req, i_sw_break, i_low_power_stop, i_breakpoint_input_n} <= {k == 0, k == 1, k == 2, k != 3};
		@(posedge i_ref_clk);
		{i_req, i_sw_break, i_low_power_stop, i_breakpoint_input_n} <= 4'h1;
		n = 0;
		@(negedge i_ref_clk);
		while (o_done !== 1'b1 && n < 300) begin
			@(negedge i_ref_clk);
			n++;
		end
		if (n >= 300) errors++;
	endtask
	initial begin
		i_ref_clk = 1'b0;
		forever #25 i_ref_clk = ~i_ref_clk;
	end
	initial begin
		repeat (10000) @(posedge i_ref_clk);
		errors++;
		tally_and_finish();
	end
	initial begin
		{i_rst, i_req, i_req_rd, i_sw_break, i_low_power_stop, i_breakpoint_input_n} = 6'h21;
		{i_req_size, i_req_addr, i_req_space, i_req_wdata, i_cs_ack_opt} = '0;
		{i_monitor_timeout_sel, m_wait, m_p16, m_mode} = '0;
		{i_sw_break_num, i_stop_mask, i_autovector_request_n} = 7'h5b;
		repeat (5) @(posedge i_ref_clk);
		i_rst <= 1'b0;
		run(0, 1, SIZE_WORD, 24'h000100, 16'h0, 4'h0, 8'h00, 1, 3'h0);
		chk(o_rdata, 16'hc35a);
		chk(o_port_16, 1'b1);
		chk(o_transfer_size, SIZE_WORD);
		run(0, 1, SIZE_BYTE, 24'h000101, 16'h0, 4'h0, 8'h05, 1, 3'h0);
		chk(o_rdata[7:0], 8'h5a);
		run(0, 1, SIZE_WORD, 24'h000102, 16'h0, 4'h0, 8'h00, 0, 3'h0);
		chk(o_rdata[7:0], 8'hc3);
		chk(o_port_16, 1'b0);
		run(0, 0, SIZE_WORD, 24'h000104, 16'h1234, 4'h0, 8'h02, 1, 3'h0);
		chk(cap_data, 16'h1234);
		chk(cap_addr, 24'h000104);
		run(0, 0, SIZE_BYTE, 24'h000107, 16'h0056, 4'h0, 8'h00, 0, 3'h0);
		chk(cap_data, 16'h5656);
		for (int i = 1; i < 5; i++) begin
			run(0, 1, SIZE_WORD, 24'h000200, 16'h0, 4'h0, 8'h01, 1, i[2:0]);
			chk(o_fault, i != 4);
			chk(o_timeout, i == 3);
		end
		for (int s = 1; s < 4; s++) begin
			@(posedge i_ref_clk);
			i_monitor_timeout_sel <= s[1:0];
			run(0, 1, SIZE_WORD, 24'h000300, 16'h0, 4'h0, 8'h00, 1, 3'h3);
			chk(o_timeout, 1'b1);
		end
		run(0, 1, SIZE_WORD, 24'h000400, 16'h0, ACK_OPT_FAST, 8'h00, 1, 3'h3);
		chk(o_fault, 1'b0);
		chk(o_rdata, 16'hc35a);
		chk(o_port_16, 1'b1);
		run(0, 0, SIZE_WORD, 24'h000402, 16'h9abc, ACK_OPT_FAST, 8'h00, 1, 3'h3);
		chk(cap_data, 16'h9abc);
		run(2, 0, SIZE_WORD, 24'h0, 16'h0, 4'h0, 8'h00, 1, 3'h3);
		chk(cap_addr, 24'h03fffe);
		chk(cap_data, 16'h0005);
		chk(cap_space, SPACE_CPU);
		run(1, 1, SIZE_WORD, 24'h0, 16'h0, 4'h0, 8'h00, 1, 3'h0);
		chk(cap_addr, 24'h000014);
		chk(cap_space, SPACE_CPU);
		run(3, 1, SIZE_WORD, 24'h0, 16'h0, 4'h0, 8'h00, 1, 3'h0);
		chk(cap_addr, 24'h00001e);
		tally_and_finish();
	end
endmodule
bind ebc_bus_ctrl ebc_bus_ctrl_asserts chk_i (.*);

//--- ebc_bus_monitor.sv
// Bus monitor: flags a cycle that waits past the selected limit
module ebc_bus_monitor import ebc_pkg::*; #(
	parameter int MAX_CYC = MON_MAX_CYC
) (
	input wire logic i_ref_clk, // System clock
	input wire logic i_rst, // Synchronous reset
	ebc_mon_if.mon mon // Sequencer link
);
	logic [MON_CNT_W-1:0] cnt_reg;
	logic [MON_CNT_W-1:0] cnt_next;
	logic expired_reg;
	logic expired_next;
	wire [MON_CNT_W-1:0] limit = ebc_mon_limit(mon.sel);

	if (MAX_CYC > MON_MAX_CYC || MAX_CYC < 1) begin : g_chk
		$error("bus monitor limit out of range");
	end

	// No enable input exists: the monitor runs on every waiting cycle
	assign cnt_next = mon.active ? cnt_reg + 7'h01 : '0; // [RULE6]
	assign expired_next = mon.active && (cnt_next >= limit) && !expired_reg; // [RULE6]

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			cnt_reg <= '0;
			expired_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			expired_reg <= expired_next;
		end
	end

	assign mon.expired = expired_reg;
endmodule

//--- ebc_mon_if.sv
// Link between the cycle sequencer and the bus monitor
interface ebc_mon_if;
	logic active;
	logic [1:0] sel;
	logic expired;
	modport ctl (output active, output sel, input expired);
	modport mon (input active, input sel, output expired);
endinterface

//--- ebc_periph_model.sv
// Far-side memory model answering after a set wait with a chosen response
module ebc_periph_model (
	input wire logic i_clk, // Clock
	input wire logic i_as_n, // Address strobe
	input wire logic i_rd_wr, // Direction
	input wire logic [23:0] i_addr, // Address
	input wire logic [2:0] i_space, // Space code
	input wire logic [15:0] i_bus, // Resolved data bus
	input wire logic [7:0] i_wait, // Wait clocks
	input wire logic i_p16, // 16-bit port
	input wire logic [2:0] i_mode, // 0 ack,1 fault,2 fault+halt,3 none,4 halt+ack
	output logic [1:0] o_ack_n, // Ack pins
	output logic o_fault_n, // Fault pin
	output logic o_halt_n, // Halt pin
	output logic [15:0] o_data, // Read data
	output logic [23:0] o_cap_addr, // Last address
	output logic [2:0] o_cap_space, // Last space
	output logic [15:0] o_cap_data // Last write data
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] cnt = 8'h00;
	logic [15:0] last = 16'h0000;
	logic go;
	assign go = (i_as_n === 1'b0) && cnt >= i_wait;
	assign o_ack_n = (go && (i_mode == 3'h0 || i_mode == 3'h4)) ? (i_p16 ? 2'h1 : 2'h2) : 2'h3;
	assign o_fault_n = !(go && (i_mode == 3'h1 || i_mode == 3'h2));
	assign o_halt_n = !(go && (i_mode == 3'h2 || i_mode == 3'h4));
	// Released bus toggles so a late latch cannot pick up stale data
	assign o_data = (i_as_n === 1'b0 && i_rd_wr === 1'b1) ? 16'hc35a : ~last;
	always @(posedge i_clk) begin
		last <= o_data;
		cnt <= (i_as_n !== 1'b0) ? 8'h00 : cnt + 8'h01;
		if (!i_as_n) begin
			o_cap_addr <= i_addr;
			o_cap_space <= i_space;
			if (!i_rd_wr) begin
				o_cap_data <= i_bus;
			end
		end
	end
endmodule

//--- ebc_pkg.sv
// Shared constants, encodings and state type for the external bus cycle controller
package ebc_pkg;
	localparam int ADDR_W = 24;
	localparam int DATA_W = 16;
	localparam int MON_CNT_W = 7;
	localparam int MON_MAX_CYC = 64;

	// Operand length codes on the transfer_size lines
	localparam logic [1:0] SIZE_LONG = 2'h0;
	localparam logic [1:0] SIZE_BYTE = 2'h1;
	localparam logic [1:0] SIZE_WORD = 2'h2;
	localparam logic [1:0] SIZE_3BYTE = 2'h3;

	// Raw active-low data_size_ack codes
	localparam logic [1:0] ACK_NONE = 2'h3;
	localparam logic [1:0] ACK_8BIT = 2'h2;
	localparam logic [1:0] ACK_16BIT = 2'h1;

	localparam logic [2:0] SPACE_CPU = 3'h7;
	localparam logic [3:0] CPU_BRKACK = 4'h0;
	localparam logic [3:0] CPU_STOPCAST = 4'h3;
	localparam logic [3:0] CPU_IACK = 4'hf;
	localparam int CPU_TYPE_LSB = 16;

	localparam logic [3:0] ACK_OPT_FAST = 4'he;

	localparam logic [23:0] HW_BRK_ADDR = 24'h00001e;
	localparam logic [23:0] STOPCAST_ADDR = 24'h03fffe;
	localparam int SW_BRK_NUM_LSB = 2;

	// Monitor limits per monitor_timeout_sel code, in system clocks
	localparam logic [6:0] MON_LIM_0 = 7'h40;
	localparam logic [6:0] MON_LIM_1 = 7'h20;
	localparam logic [6:0] MON_LIM_2 = 7'h10;
	localparam logic [6:0] MON_LIM_3 = 7'h08;

	localparam logic [23:0] ADDR_RST = 24'h000000;
	localparam logic [15:0] DATA_RST = 16'h0000;

	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_ADDR = 5'b00010,
		ST_WAIT = 5'b00100,
		ST_LATCH = 5'b01000,
		ST_FAST = 5'b10000
	} ebc_state_t;

	function automatic logic [6:0] ebc_mon_limit(input logic [1:0] sel);
		logic [6:0] lim;
		case (sel)
			2'h0: lim = MON_LIM_0;
			2'h1: lim = MON_LIM_1;
			2'h2: lim = MON_LIM_2;
			default: lim = MON_LIM_3;
		endcase
		return lim;
	endfunction

	function automatic logic ebc_acked(input logic [1:0] ack, input logic vec_n);
		return (ack != ACK_NONE) || !vec_n;
	endfunction
endpackage
